// ===== rtl/ibtq_defs.svh
/*
 Register offsets, field positions, reset values and code points of the image block
 transfer queue. Assumes byte addressing on a 32-bit Avalon-MM register bus.
*/
`ifndef IBTQ_DEFS_SVH
`define IBTQ_DEFS_SVH

`define IBTQ_AW 6
`define IBTQ_OFS_CTRL_METHOD 6'h00
`define IBTQ_OFS_OP_SELECT 6'h04
`define IBTQ_OFS_BURST_TOTAL 6'h08
`define IBTQ_OFS_CAPACITY 6'h0c
`define IBTQ_OFS_OCCUPANCY 6'h10
`define IBTQ_OFS_LOST 6'h14
`define IBTQ_OFS_POLICY 6'h18
`define IBTQ_OFS_COMMAND 6'h1c
`define IBTQ_OFS_IRQ_STATUS 6'h20
`define IBTQ_OFS_IRQ_MASK 6'h24
`define IBTQ_OFS_STATE 6'h28

`define IBTQ_CMD_GO_BIT 0
`define IBTQ_CMD_HALT_BIT 1
`define IBTQ_CMD_CLOSE_BIT 2

`define IBTQ_EV_SENT_BIT 0
`define IBTQ_EV_LOST_BIT 1
`define IBTQ_EV_BURST_BIT 2
`define IBTQ_NUM_EV 3

`define IBTQ_ST_RUN_BIT 0
`define IBTQ_ST_BUSY_BIT 1

`define IBTQ_RST_METHOD 2'h0
`define IBTQ_RST_OP 1'h0
`define IBTQ_RST_POLICY 1'h0

`endif

// ===== rtl/ibtq_irq.sv
/*
 Sticky event flags, write-one-to-clear, with a mask and one level interrupt.
 Assumes event pulses and clear strobes are synchronous to clk_i.
*/
`timescale 1ns/1ps
module ibtq_irq #(
    parameter int NE = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NE-1:0] event_i,
    input wire logic clr_wr_i,
    input wire logic mask_wr_i,
    input wire logic [NE-1:0] wdata_i,
    output logic [NE-1:0] status_o,
    output logic [NE-1:0] mask_o,
    output logic irq_o
);
    logic [NE-1:0] status_d;

    genvar i;
    for (i = 0; i < NE; i++) begin : g_flag
        // A new event in the clearing cycle survives the clear
        assign status_d[i] = event_i[i] || (status_o[i] && !(clr_wr_i && wdata_i[i]));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_o <= '0;
            mask_o <= '0;
            irq_o <= 1'b0;
        end else begin
            status_o <= status_d;
            mask_o <= mask_wr_i ? wdata_i : mask_o;
            irq_o <= |(status_d & (mask_wr_i ? wdata_i : mask_o));
        end
    end
endmodule

// ===== rtl/ibtq_pkg.sv
/*
 Types of the image block transfer queue: control methods, operation modes, sender states.
 Assumes ibtq_defs.svh is included by the modules that need numeric constants.
*/
package ibtq_pkg;
    typedef enum logic [1:0] {
        IBTQ_BASIC = 2'h0,
        IBTQ_AUTO = 2'h1,
        IBTQ_USER = 2'h2
    } ibtq_method_type;

    typedef enum logic [0:0] {
        IBTQ_CONTINUOUS = 1'h0,
        IBTQ_MULTI = 1'h1
    } ibtq_op_type;

    typedef enum logic [0:0] {
        IBTQ_FIFO = 1'h0
    } ibtq_policy_type;

    typedef enum logic [0:0] {
        IBTQ_IDLE = 1'h0,
        IBTQ_SEND = 1'h1
    } ibtq_tx_state_type;
endpackage

// ===== rtl/ibtq_q_if.sv
/*
 Carrier between the transfer controller and its block queue.
 Assumes both ends share one clock; all strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
interface ibtq_q_if #(parameter int DW = 32, parameter int CW = 16);
    logic push;
    logic [DW-1:0] push_data;
    logic pop;
    logic flush;
    logic [DW-1:0] head;
    logic [CW-1:0] count;
    logic empty;
    logic overwrite;

    modport ctrl (output push, push_data, pop, flush, input head, count, empty, overwrite);
    modport fifo (input push, push_data, pop, flush, output head, count, empty, overwrite);
endinterface

// ===== rtl/ibtq_queue.sv
/*
 First-in-first-out store of block descriptors. A lone push into a full store drops the head,
 which is always the oldest block not yet begun, since a block leaves when it starts.
 Assumes pop is only given while not empty.
*/
`timescale 1ns/1ps
module ibtq_queue import ibtq_pkg::*; #(
    parameter int DW = 32,
    parameter int CW = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    ibtq_q_if.fifo q
);
    localparam int PW = $clog2(DEPTH);

    logic [DW-1:0] mem [DEPTH];
    logic [PW-1:0] rd_q;
    logic [PW-1:0] wr_q;
    logic [CW-1:0] cnt_q;

    wire full = (cnt_q == CW'(DEPTH));
    wire pop_ok = q.pop && (cnt_q != '0);
    // A simultaneous pop frees a slot, so only a lone push into a full store overwrites
    wire drop = q.push && full && !pop_ok;
    wire adv_rd = pop_ok || drop;
    wire [PW-1:0] rd_nx = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    wire [PW-1:0] wr_nx = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;

    assign q.head = mem[rd_q];
    assign q.count = cnt_q;
    assign q.empty = (cnt_q == '0);
    assign q.overwrite = drop;

    always_ff @(posedge clk_i) begin
        if (q.push && !q.flush) begin
            mem[wr_q] <= q.push_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
        end else if (q.flush) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
        end else begin
            rd_q <= adv_rd ? rd_nx : rd_q;
            wr_q <= q.push ? wr_nx : wr_q;
            cnt_q <= cnt_q + CW'(q.push && !drop) - CW'(pop_ok);
        end
    end
endmodule

// ===== rtl/ibtq_top.sv
/*
 Image block transfer queue: takes finished block descriptors, queues them first in first
 out and hands them one at a time to the link layer, under basic, automatic or user control.
 Assumes an Avalon-MM master with waitrequest, and a link layer that takes a descriptor on
 TX_START_O and reports the end of that block with one TX_DONE_I pulse.
*/
`timescale 1ns/1ps
`include "ibtq_defs.svh"
module ibtq_top import ibtq_pkg::*; #(
    parameter int DW = 32,
    parameter int CW = 16,
    parameter int DEPTH = 8
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [`IBTQ_AW-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic BLK_DONE_I,
    input wire logic [DW-1:0] BLK_DESC_I,
    input wire logic PKT_READY_I,
    input wire logic [DW-1:0] ACQ_DESC_I,
    output logic TX_START_O,
    output logic [DW-1:0] TX_DESC_O,
    input wire logic TX_DONE_I,
    output logic STREAMING_O,
    output logic IRQ_O
);
    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    logic ack_q;
    logic wait_q;
    logic [31:0] rdata_q;
    ibtq_method_type method_q;
    ibtq_op_type op_q;
    logic [CW-1:0] burst_total_q;
    logic [CW-1:0] lost_q;
    ibtq_policy_type policy_q;

    wire req = AVS_READ_I || AVS_WRITE_I;
    // A write lands on the edge at which waitrequest is seen low
    wire wr_en = AVS_WRITE_I && ack_q;
    wire wr_method = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_CTRL_METHOD);
    wire wr_op = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_OP_SELECT);
    wire wr_burst = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_BURST_TOTAL);
    wire wr_policy = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_POLICY);
    wire wr_cmd = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_COMMAND);
    wire wr_clr = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_IRQ_STATUS);
    wire wr_mask = wr_en && (AVS_ADDRESS_I == `IBTQ_OFS_IRQ_MASK);
    wire user_ctl = (method_q == IBTQ_USER);
    wire go_cmd = wr_cmd && AVS_WRITEDATA_I[`IBTQ_CMD_GO_BIT] && user_ctl;
    wire halt_cmd = wr_cmd && AVS_WRITEDATA_I[`IBTQ_CMD_HALT_BIT] && user_ctl;
    wire close_cmd = wr_cmd && AVS_WRITEDATA_I[`IBTQ_CMD_CLOSE_BIT];
    // Unknown method codes are refused so the enum never holds an illegal value
    wire method_ok = (AVS_WRITEDATA_I[1:0] != 2'h3);

    ibtq_q_if #(.DW(DW), .CW(CW)) qif ();
    logic [`IBTQ_NUM_EV-1:0] ev_status;
    logic [`IBTQ_NUM_EV-1:0] ev_mask;
    logic irq_w;
    logic run_q;
    ibtq_tx_state_type state_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0;
        unique case (AVS_ADDRESS_I)
            `IBTQ_OFS_CTRL_METHOD: rdata_d = 32'(method_q);
            `IBTQ_OFS_OP_SELECT: rdata_d = 32'(op_q);
            `IBTQ_OFS_BURST_TOTAL: rdata_d = 32'(burst_total_q);
            `IBTQ_OFS_CAPACITY: rdata_d = 32'(DEPTH);
            `IBTQ_OFS_OCCUPANCY: rdata_d = 32'(qif.count);
            `IBTQ_OFS_LOST: rdata_d = 32'(lost_q);
            `IBTQ_OFS_POLICY: rdata_d = 32'(policy_q);
            `IBTQ_OFS_IRQ_STATUS: rdata_d = 32'(ev_status);
            `IBTQ_OFS_IRQ_MASK: rdata_d = 32'(ev_mask);
            `IBTQ_OFS_STATE: rdata_d = {30'h0, (state_q == IBTQ_SEND), run_q};
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req && !ack_q;
            // Own flop so the pin does not pass through an inverter
            wait_q <= !(req && !ack_q);
            rdata_q <= rdata_d;
        end
    end

    assign AVS_READDATA_O = rdata_q;
    assign AVS_WAITREQUEST_O = wait_q;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            method_q <= ibtq_method_type'(`IBTQ_RST_METHOD);
            op_q <= ibtq_op_type'(`IBTQ_RST_OP);
            burst_total_q <= '0;
            policy_q <= ibtq_policy_type'(`IBTQ_RST_POLICY);
        end else begin
            if (wr_method && method_ok) begin
                method_q <= ibtq_method_type'(AVS_WRITEDATA_I[1:0]);
            end
            if (wr_op) begin
                op_q <= ibtq_op_type'(AVS_WRITEDATA_I[0]);
            end
            if (wr_burst) begin
                burst_total_q <= AVS_WRITEDATA_I[CW-1:0];
            end
            // Only first-in-first-out exists, so any other code is dropped
            if (wr_policy && (AVS_WRITEDATA_I[0] == 1'b0)) begin
                policy_q <= IBTQ_FIFO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue

    logic cut_q;
    logic [CW-1:0] remain_q;

    // A block already cut through to the link is not queued a second time
    assign qif.push = BLK_DONE_I && !cut_q && !close_cmd;
    assign qif.push_data = BLK_DESC_I;
    assign qif.flush = close_cmd;

    ibtq_queue #(.DW(DW), .CW(CW), .DEPTH(DEPTH)) i_ibtq_queue (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .q(qif.fifo)
    );

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lost_q <= '0;
        end else if (qif.overwrite) begin
            lost_q <= lost_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmission control

    wire multi = (op_q == IBTQ_MULTI);
    // Basic and automatic never wait for commands
    wire enabled = user_ctl ? run_q : 1'b1;
    wire can_launch = (state_q == IBTQ_IDLE) && enabled && !close_cmd;
    wire launch_q = can_launch && !qif.empty;
    // Cut-through only when nothing older waits, so first-in-first-out order holds
    // A block entering the queue this cycle is older than the one being acquired
    wire launch_cut = can_launch && qif.empty && !qif.push && !user_ctl && PKT_READY_I
                      && !cut_q;
    wire launch = launch_q || launch_cut;
    wire burst_last = user_ctl && multi && launch && (remain_q == CW'(1));

    assign qif.pop = launch_q;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_q <= 1'b0;
            remain_q <= '0;
        end else if (close_cmd || !user_ctl) begin
            run_q <= 1'b0;
            remain_q <= '0;
        end else if (go_cmd) begin
            // Block total is consulted only in multi-block mode
            run_q <= multi ? (burst_total_q != '0) : 1'b1;
            remain_q <= multi ? burst_total_q : '0;
        end else if (halt_cmd || burst_last) begin
            run_q <= 1'b0;
            remain_q <= '0;
        end else if (multi && launch) begin
            remain_q <= remain_q - 1'b1;
        end
    end

    // Stop clears run_q and remain_q only; a block in SEND still runs to TX_DONE_I
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= IBTQ_IDLE;
        end else begin
            unique case (state_q)
                IBTQ_IDLE: state_q <= launch ? IBTQ_SEND : IBTQ_IDLE;
                IBTQ_SEND: state_q <= TX_DONE_I ? IBTQ_IDLE : IBTQ_SEND;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cut_q <= 1'b0;
        end else if (close_cmd || BLK_DONE_I) begin
            cut_q <= 1'b0;
        end else if (launch_cut) begin
            cut_q <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TX_START_O <= 1'b0;
            TX_DESC_O <= '0;
            STREAMING_O <= 1'b0;
        end else begin
            TX_START_O <= launch;
            TX_DESC_O <= launch_cut ? ACQ_DESC_I : (launch_q ? qif.head : TX_DESC_O);
            STREAMING_O <= launch || ((state_q == IBTQ_SEND) && !TX_DONE_I);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    wire burst_end_ev = burst_last;
    wire [`IBTQ_NUM_EV-1:0] events = {burst_end_ev, qif.overwrite,
                                      (state_q == IBTQ_SEND) && TX_DONE_I};

    ibtq_irq #(.NE(`IBTQ_NUM_EV)) i_ibtq_irq (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .event_i(events),
        .clr_wr_i(wr_clr),
        .mask_wr_i(wr_mask),
        .wdata_i(AVS_WRITEDATA_I[`IBTQ_NUM_EV-1:0]),
        .status_o(ev_status),
        .mask_o(ev_mask),
        .irq_o(irq_w)
    );

    assign IRQ_O = irq_w;
endmodule

// ===== tb/ibtq_link_model.sv
/*
 Link layer stand-in: ends each launched block with one done pulse.
 Assumes launches never overlap; slow_i picks a long transfer time.
*/
`timescale 1ns/1ps
module ibtq_link_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_start_i,
    input wire logic slow_i,
    output logic tx_done_o
);
    int cnt_q;
    // A slow block outlasts a few register writes, so stop can land mid-block
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 0;
            tx_done_o <= 1'b0;
        end else begin
            tx_done_o <= (cnt_q == 1);
            if (tx_start_i) begin
                cnt_q <= slow_i ? 20 : 3;
            end else if (cnt_q > 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule

// ===== tb/ibtq_top_assertions.sv
/*
 Port checker for the transfer queue top, bound to every ibtq_top.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ibtq_top_assertions import ibtq_pkg::*; #(
    parameter int DW = 32
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic TX_START_O,
    input wire logic [DW-1:0] TX_DESC_O,
    input wire logic TX_DONE_I,
    input wire logic STREAMING_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////
    AST_BUS_ANSWER: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |->
        AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("bus answer not on the second edge");
    AST_BUS_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low too long");
    AST_START_PULSE: assert property (TX_START_O |=> !TX_START_O)
        else $error("start pulse longer than one cycle");
    AST_START_STREAM: assert property (TX_START_O |-> STREAMING_O)
        else $error("start without streaming flag");
    AST_NO_OVERLAP: assert property (STREAMING_O |=> !TX_START_O)
        else $error("launch while a block is in flight");
    AST_NO_CUT: assert property (STREAMING_O && !TX_DONE_I |=> STREAMING_O)
        else $error("block cut short");
    AST_END_BLOCK: assert property (STREAMING_O && TX_DONE_I |=> !STREAMING_O)
        else $error("streaming flag kept after done");
    AST_DESC_HOLD: assert property (!TX_START_O |-> $stable(TX_DESC_O))
        else $error("descriptor changed without launch");
endmodule
bind ibtq_top ibtq_top_assertions #(.DW(DW)) i_ibtq_top_assertions (
    .REF_CLK_I(REF_CLK_I),
    .RST_N_I(RST_N_I),
    .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .TX_START_O(TX_START_O),
    .TX_DESC_O(TX_DESC_O),
    .TX_DONE_I(TX_DONE_I),
    .STREAMING_O(STREAMING_O)
);

// ===== tb/tb_ibtq_top.sv
/*
 Register-level bench of the transfer queue with a link model.
 Assumes a four-deep queue so that overflow is reached quickly.
*/
`timescale 1ns/1ps
`include "ibtq_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_ibtq_top import ibtq_pkg::*; ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic bdone = 1'b0;
    logic [31:0] bdesc = 32'h0;
    logic pkt = 1'b0;
    logic [31:0] acq = 32'h0;
    logic txs;
    logic [31:0] txd;
    logic txdn;
    logic strm;
    logic irq;
    logic slow = 1'b0;
    logic [31:0] rv;
    logic [31:0] sent[$];
    int fails = 0;
    int tests_run = 0;
    ////////////////////////////////////////
    ibtq_top #(.DEPTH(4)) i_ibtq_top (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wd),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .BLK_DONE_I(bdone),
        .BLK_DESC_I(bdesc), .PKT_READY_I(pkt), .ACQ_DESC_I(acq), .TX_START_O(txs),
        .TX_DESC_O(txd), .TX_DONE_I(txdn), .STREAMING_O(strm), .IRQ_O(irq)
    );
    ibtq_link_model i_ibtq_link_model (
        .clk_i(clk), .rst_n_i(rst_n), .tx_start_i(txs), .slow_i(slow), .tx_done_o(txdn)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (txs === 1'b1) begin
            sent.push_back(txd);
        end
    end
    ////////////////////////////////////////
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr_en <= w;
        rd_en <= !w;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        rv = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rv, e)
    endtask
    // Blocks arrive back to back; the done strobe stays high between them
    task automatic push_n(input logic [31:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            bdone <= 1'b1;
            bdesc <= base + i;
            @(posedge clk);
        end
        bdone <= 1'b0;
    endtask
    task automatic wait_sent(input int n);
        for (int k = 0; k < 300 && sent.size() < n; k++) @(posedge clk);
        `CHK(sent.size(), n)
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #100us;
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`IBTQ_OFS_CAPACITY, 32'h4);
        rd(`IBTQ_OFS_OCCUPANCY, 32'h0);
        rd(`IBTQ_OFS_LOST, 32'h0);
        rd(6'h2c, 32'h0);
        wr(`IBTQ_OFS_POLICY, 32'h1);
        rd(`IBTQ_OFS_POLICY, 32'h0);
        wr(`IBTQ_OFS_COMMAND, 32'h1);
        rd(`IBTQ_OFS_STATE, 32'h0);
        acq <= 32'ha1;
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
        wait_sent(1);
        `CHK(sent[0], 32'ha1)
        push_n(32'ha1, 1);
        repeat (10) @(posedge clk);
        rd(`IBTQ_OFS_OCCUPANCY, 32'h0);
        wr(`IBTQ_OFS_BURST_TOTAL, 32'h1);
        wr(`IBTQ_OFS_CTRL_METHOD, {30'h0, IBTQ_USER});
        push_n(32'hb0, 5);
        rd(`IBTQ_OFS_OCCUPANCY, 32'h4);
        rd(`IBTQ_OFS_LOST, 32'h1);
        `CHK(sent.size(), 1)
        wr(`IBTQ_OFS_IRQ_MASK, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(`IBTQ_OFS_IRQ_STATUS, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(`IBTQ_OFS_COMMAND, 32'h1);
        wait_sent(5);
        for (int i = 1; i < 5; i++) `CHK(sent[i], 32'hb0 + i)
        slow <= 1'b1;
        push_n(32'hc0, 3);
        wr(`IBTQ_OFS_COMMAND, 32'h2);
        repeat (60) @(posedge clk);
        `CHK(sent.size(), 6)
        rd(`IBTQ_OFS_OCCUPANCY, 32'h2);
        wr(`IBTQ_OFS_OP_SELECT, 32'h1);
        wr(`IBTQ_OFS_BURST_TOTAL, 32'h2);
        push_n(32'hc3, 1);
        slow <= 1'b0;
        wr(`IBTQ_OFS_COMMAND, 32'h1);
        repeat (60) @(posedge clk);
        `CHK(sent.size(), 8)
        `CHK(sent[7], 32'hc2)
        rd(`IBTQ_OFS_OCCUPANCY, 32'h1);
        wr(`IBTQ_OFS_COMMAND, 32'h4);
        rd(`IBTQ_OFS_OCCUPANCY, 32'h0);
        wr(`IBTQ_OFS_CTRL_METHOD, 32'h1);
        push_n(32'hd0, 1);
        wait_sent(9);
        `CHK(strm, 1'b1)
        `CHK(sent[8], 32'hd0)
        repeat (20) @(posedge clk);
        `CHK(strm, 1'b0)
        tally_and_finish;
    end
endmodule
